// ===== reset_seq_defines.svh
`ifndef RESET_SEQ_DEFINES_SVH
`define RESET_SEQ_DEFINES_SVH

// ----------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------
`define CLK_MHZ 200
`define POR_DELAY_NS 10000
`define VREG_DELAY_NS 10000
`define RST_TIME_NS 2000
`define RC_START_NS 1000
`define NS_TO_CYC(ns) ((((ns) * `CLK_MHZ) + 999) / 1000)
`define POR_CYC `NS_TO_CYC(`POR_DELAY_NS)
`define VREG_CYC `NS_TO_CYC(`VREG_DELAY_NS)
`define RST_CYC `NS_TO_CYC(`RST_TIME_NS)
`define RC_START_CYC `NS_TO_CYC(`RC_START_NS)
`define OST_PERIODS 1024

// ----------------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------------
`define OFS_CAUSE 8'h00
`define OFS_OSC 8'h04
`define OFS_RTC 8'h08
`define OFS_FLASH 8'h0c
`define OFS_CFG2 8'h10
`define OFS_CFG3 8'h14
`define OFS_STATUS 8'h18

// ----------------------------------------------------------------------
// Fields and reset values
// ----------------------------------------------------------------------
`define CAUSE_TRAP 15
`define CAUSE_ILL 14
`define CAUSE_EXT 7
`define CAUSE_SOFT 6
`define CAUSE_WDT 4
`define CAUSE_BOR 1
`define CAUSE_POR 0
`define CAUSE_MASK 16'hc0d3
`define CAUSE_POR_VAL 16'h0003
`define OSC_CUR_HI 14
`define OSC_CUR_LO 12
`define OSC_NEW_HI 10
`define OSC_NEW_LO 8
`define OSC_WR_MASK 16'h0700
`define OSC_RST_VAL 16'h0000
`define CFG2_INIT_HI 10
`define CFG2_INIT_LO 8
`define CFG2_SWEN 7
`define CFG2_RST_VAL 16'h0080
`define CFG3_BO_EN 12
`define CFG3_TWOSPD 11
`define CFG3_FSCMEN 10
`define CFG3_RST_VAL 16'h1000
`define RTC_RST_VAL 16'h0000
`define FLASH_RST_VAL 16'h0000

`endif

// ===== reset_seq_pkg.sv
package reset_seq_pkg;

    typedef logic [11:0] dly_cnt_t;

    typedef enum logic [4:0] {
        ST_HOLD = 5'b00001,
        ST_POR = 5'b00010,
        ST_VREG = 5'b00100,
        ST_RST = 5'b01000,
        ST_RUN = 5'b10000
    } rst_state_t;

    typedef enum logic [3:0] {
        CK_RC = 4'b0001,
        CK_OST = 4'b0010,
        CK_LOCK = 4'b0100,
        CK_DONE = 4'b1000
    } clk_state_t;

    typedef enum logic [1:0] {
        KIND_POR = 2'h0,
        KIND_BOR = 2'h1,
        KIND_OTHER = 2'h2
    } rst_kind_t;

    typedef enum logic [2:0] {
        SRC_FAST_RC = 3'h0,
        SRC_FAST_RC_PLL = 3'h1,
        SRC_EC = 3'h2,
        SRC_ECPLL = 3'h3,
        SRC_XT = 3'h4,
        SRC_XTPLL = 3'h5,
        SRC_SOSC = 3'h6,
        SRC_SLOW_RC = 3'h7
    } osc_src_t;

endpackage

// ===== osc_startup_counter.sv
`timescale 1ns/1ps

module osc_startup_counter #(
    parameter int WIDTH = 10
) (
    input wire logic clk_in,
    input wire logic rst_in,
    input wire logic start_in,
    input wire logic tick_in,
    output logic done_out
);

    logic [WIDTH-1:0] cnt_q;
    logic run_q;

    // Counts oscillator periods from the last restart; stops and holds done_out after 2**WIDTH.
    always_ff @(posedge clk_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            cnt_q <= '0;
            run_q <= 1'b1;
            done_out <= 1'b0;
        end
        else if (start_in)
        begin
            cnt_q <= '0;
            run_q <= 1'b1;
            done_out <= 1'b0;
        end
        else if (run_q && tick_in)
        begin
            cnt_q <= cnt_q + 1'b1;
            if (cnt_q == '1)
            begin
                run_q <= 1'b0;
                done_out <= 1'b1;
            end
        end
    end

    default clocking @(posedge clk_in); endclocking
    default disable iff (rst_in);

    ost_full_count_a: assert property (
        $rose(done_out) |-> $past(cnt_q) == '1 && $past(tick_in))
        else $error("start-up timer ended before a full count");

endmodule

// ===== reset_release_sequencer.sv
// Overview of operation
// - Register reset values depend on reset type
// - Oscillator control reset follows type, config field
// - RTC and flash control cleared only by POR
// - POR: power-on, regulator, then internal delays
// - Clock waits run alongside reset delay
// - Enabled brown-out causes device reset
// - Switching on: POR/BOR config, others current
// - Switching off: always take config source
// - Power-on delay 10 us, POR only
// - POR and BOR add 10 us regulator delay
// - Other resets use only 2 us delay
// - Crystal start-up counts 1024 oscillator periods
// - POR/BOR clock delay matches source type
// - Two-speed: run fast RC, then switch primary
// - No execution before a clock is released
// - Monitor armed at release; falls to fast RC
// - Each reset type sets a flag; illegal opcode and uninit W share bit 14
// - POR clears flags, sets brown-out and power-on
//
// The register addresses and the APB slave port were left to the implementer.
`timescale 1ns/1ps
`include "reset_seq_defines.svh"

module reset_release_sequencer #(
    parameter int OST_WIDTH = 10
) (
    input wire logic clk_in,
    input wire logic rst_in,
    input wire logic psel_in,
    input wire logic penable_in,
    input wire logic pwrite_in,
    input wire logic [7:0] paddr_in,
    input wire logic [31:0] pwdata_in,
    output logic [31:0] prdata_out,
    output logic pready_out,
    output logic pslverr_out,
    input wire logic brown_out_in,
    input wire logic external_reset_pin_in,
    input wire logic watchdog_timeout_reset_in,
    input wire logic software_reset_instr_in,
    input wire logic illegal_opcode_in,
    input wire logic uninit_wreg_in,
    input wire logic trap_conflict_in,
    input wire logic osc_tick_in,
    input wire logic pll_lock_in,
    input wire logic clk_present_in,
    output logic system_reset_out,
    output logic cpu_run_out,
    output logic clock_fail_out,
    output logic [2:0] active_osc_out
);

    // ------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------
    function automatic logic is_ost(input logic [2:0] s);
        is_ost = (s == reset_seq_pkg::SRC_XT) ||
            (s == reset_seq_pkg::SRC_XTPLL) ||
            (s == reset_seq_pkg::SRC_SOSC);
    endfunction

    function automatic logic is_pll(input logic [2:0] s);
        is_pll = (s == reset_seq_pkg::SRC_FAST_RC_PLL) ||
            (s == reset_seq_pkg::SRC_ECPLL) ||
            (s == reset_seq_pkg::SRC_XTPLL);
    endfunction

    function automatic logic is_rc(input logic [2:0] s);
        is_rc = (s == reset_seq_pkg::SRC_FAST_RC) ||
            (s == reset_seq_pkg::SRC_FAST_RC_PLL) ||
            (s == reset_seq_pkg::SRC_SLOW_RC);
    endfunction

    function automatic reset_seq_pkg::clk_state_t first_ck(
        input logic [2:0] s);
        if (is_rc(s))
            first_ck = reset_seq_pkg::CK_RC;
        else if (is_ost(s))
            first_ck = reset_seq_pkg::CK_OST;
        else if (is_pll(s))
            first_ck = reset_seq_pkg::CK_LOCK;
        else
            first_ck = reset_seq_pkg::CK_DONE;
    endfunction

    function automatic logic decode_hit(input logic [7:0] a);
        decode_hit = (a == `OFS_CAUSE) || (a == `OFS_OSC) ||
            (a == `OFS_RTC) || (a == `OFS_FLASH) || (a == `OFS_CFG2) ||
            (a == `OFS_CFG3) || (a == `OFS_STATUS);
    endfunction

    // ------------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------------
    reset_seq_pkg::rst_state_t state_q;
    reset_seq_pkg::clk_state_t ck_q;
    reset_seq_pkg::rst_kind_t kind_q;
    reset_seq_pkg::dly_cnt_t cnt_q;
    reset_seq_pkg::dly_cnt_t rc_cnt_q;
    logic [15:0] cause_q, osc_q, rtc_q, flash_q, cfg2_q, cfg3_q;
    logic [15:0] cause_set, rd_mux;
    logic [2:0] sel_src, tgt_src;
    logic bor_src, pin_src, any_src, reselect, restart, release_w;
    logic acc, wr, two_q, mon_q, rc_done, ost_done, clk_rel;

    assign bor_src = brown_out_in & cfg3_q[`CFG3_BO_EN];
    assign pin_src = external_reset_pin_in | watchdog_timeout_reset_in |
        software_reset_instr_in | illegal_opcode_in | uninit_wreg_in |
        trap_conflict_in;
    assign any_src = bor_src | pin_src;
    assign release_w = (state_q == reset_seq_pkg::ST_RST) && !any_src;
    assign reselect = any_src && ((state_q == reset_seq_pkg::ST_RUN) ||
        (bor_src && kind_q == reset_seq_pkg::KIND_OTHER));
    assign restart = reselect && bor_src;
    assign tgt_src = osc_q[`OSC_NEW_HI:`OSC_NEW_LO];

    // Switching disabled or a brown-out: the configured source wins.
    always_comb
    begin
        if (cfg2_q[`CFG2_SWEN] && !bor_src)
            sel_src = osc_q[`OSC_CUR_HI:`OSC_CUR_LO];
        else
            sel_src = cfg2_q[`CFG2_INIT_HI:`CFG2_INIT_LO];
    end

    // ------------------------------------------------------------------
    // Reset release sequencer
    // ------------------------------------------------------------------
    always_ff @(posedge clk_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            state_q <= reset_seq_pkg::ST_POR;
            cnt_q <= 12'(`POR_CYC - 1);
            kind_q <= reset_seq_pkg::KIND_POR;
        end
        else if (any_src)
        begin
            state_q <= reset_seq_pkg::ST_HOLD;
            if (bor_src)
                kind_q <= (state_q != reset_seq_pkg::ST_RUN &&
                    kind_q == reset_seq_pkg::KIND_POR) ?
                    reset_seq_pkg::KIND_POR : reset_seq_pkg::KIND_BOR;
            else if (state_q == reset_seq_pkg::ST_RUN)
                kind_q <= reset_seq_pkg::KIND_OTHER;
        end
        else
        begin
            case (state_q)
                reset_seq_pkg::ST_HOLD:
                begin
                    case (kind_q)
                        reset_seq_pkg::KIND_POR:
                        begin
                            state_q <= reset_seq_pkg::ST_POR;
                            cnt_q <= 12'(`POR_CYC - 1);
                        end
                        reset_seq_pkg::KIND_BOR:
                        begin
                            state_q <= reset_seq_pkg::ST_VREG;
                            cnt_q <= 12'(`VREG_CYC - 1);
                        end
                        default:
                        begin
                            state_q <= reset_seq_pkg::ST_RST;
                            cnt_q <= 12'(`RST_CYC - 1);
                        end
                    endcase
                end
                reset_seq_pkg::ST_POR:
                begin
                    if (cnt_q == '0)
                    begin
                        state_q <= reset_seq_pkg::ST_VREG;
                        cnt_q <= 12'(`VREG_CYC - 1);
                    end
                    else
                        cnt_q <= cnt_q - 1'b1;
                end
                reset_seq_pkg::ST_VREG:
                begin
                    if (cnt_q == '0)
                    begin
                        state_q <= reset_seq_pkg::ST_RST;
                        cnt_q <= 12'(`RST_CYC - 1);
                    end
                    else
                        cnt_q <= cnt_q - 1'b1;
                end
                reset_seq_pkg::ST_RST:
                begin
                    if (cnt_q == '0)
                        state_q <= reset_seq_pkg::ST_RUN;
                    else
                        cnt_q <= cnt_q - 1'b1;
                end
                reset_seq_pkg::ST_RUN:
                    state_q <= reset_seq_pkg::ST_RUN;
                default:
                    state_q <= reset_seq_pkg::ST_HOLD;
            endcase
        end
    end

    assign system_reset_out = (state_q != reset_seq_pkg::ST_RUN);

    // ------------------------------------------------------------------
    // System clock wait, runs beside the reset delay
    // ------------------------------------------------------------------
    osc_startup_counter #(
        .WIDTH(OST_WIDTH)
    ) u_ost (
        .clk_in(clk_in),
        .rst_in(rst_in),
        .start_in(restart),
        .tick_in(osc_tick_in),
        .done_out(ost_done)
    );

    assign rc_done = (rc_cnt_q == '0);

    // The wait is not gated by the reset state, so it overlaps it.
    always_ff @(posedge clk_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            ck_q <= reset_seq_pkg::CK_RC;
            rc_cnt_q <= 12'(`RC_START_CYC - 1);
            two_q <= 1'b0;
        end
        else if (restart)
        begin
            ck_q <= first_ck(sel_src);
            rc_cnt_q <= 12'(`RC_START_CYC - 1);
            two_q <= cfg3_q[`CFG3_TWOSPD] && is_ost(sel_src);
        end
        else
        begin
            if (!rc_done)
                rc_cnt_q <= rc_cnt_q - 1'b1;
            case (ck_q)
                reset_seq_pkg::CK_RC:
                    if (rc_done)
                        ck_q <= is_pll(tgt_src) ? reset_seq_pkg::CK_LOCK :
                            reset_seq_pkg::CK_DONE;
                reset_seq_pkg::CK_OST:
                    if (ost_done)
                        ck_q <= is_pll(tgt_src) ? reset_seq_pkg::CK_LOCK :
                            reset_seq_pkg::CK_DONE;
                reset_seq_pkg::CK_LOCK:
                    if (pll_lock_in)
                        ck_q <= reset_seq_pkg::CK_DONE;
                reset_seq_pkg::CK_DONE:
                    ck_q <= reset_seq_pkg::CK_DONE;
                default:
                    ck_q <= reset_seq_pkg::CK_DONE;
            endcase
            if (ck_q == reset_seq_pkg::CK_DONE)
                two_q <= 1'b0;
        end
    end

    assign clk_rel = (ck_q == reset_seq_pkg::CK_DONE) || (two_q && rc_done);
    assign cpu_run_out = !system_reset_out && clk_rel;

    // ------------------------------------------------------------------
    // Oscillator control and clock fail monitor
    // ------------------------------------------------------------------
    always_ff @(posedge clk_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            osc_q <= `OSC_RST_VAL;
            mon_q <= 1'b0;
            clock_fail_out <= 1'b0;
        end
        else
        begin
            clock_fail_out <= 1'b0;
            if (system_reset_out)
                mon_q <= release_w && cfg3_q[`CFG3_FSCMEN];
            if (reselect)
            begin
                osc_q[`OSC_NEW_HI:`OSC_NEW_LO] <= sel_src;
                osc_q[`OSC_CUR_HI:`OSC_CUR_LO] <=
                    (bor_src && cfg3_q[`CFG3_TWOSPD] && is_ost(sel_src)) ?
                    reset_seq_pkg::SRC_FAST_RC : sel_src;
            end
            else if (mon_q && !clk_present_in && !system_reset_out &&
                osc_q[`OSC_CUR_HI:`OSC_CUR_LO] != reset_seq_pkg::SRC_FAST_RC)
            begin
                osc_q[`OSC_CUR_HI:`OSC_CUR_LO] <= reset_seq_pkg::SRC_FAST_RC;
                clock_fail_out <= 1'b1;
            end
            else if (two_q && ck_q == reset_seq_pkg::CK_DONE)
                osc_q[`OSC_CUR_HI:`OSC_CUR_LO] <= tgt_src;
            else if (wr && paddr_in == `OFS_OSC)
                osc_q <= (osc_q & ~`OSC_WR_MASK) |
                    (pwdata_in[15:0] & `OSC_WR_MASK);
        end
    end

    assign active_osc_out = osc_q[`OSC_CUR_HI:`OSC_CUR_LO];

    // ------------------------------------------------------------------
    // Reset cause flags
    // ------------------------------------------------------------------
    always_comb
    begin
        cause_set = 16'h0000;
        cause_set[`CAUSE_TRAP] = trap_conflict_in;
        cause_set[`CAUSE_ILL] = illegal_opcode_in | uninit_wreg_in;
        cause_set[`CAUSE_EXT] = external_reset_pin_in;
        cause_set[`CAUSE_SOFT] = software_reset_instr_in;
        cause_set[`CAUSE_WDT] = watchdog_timeout_reset_in;
        cause_set[`CAUSE_BOR] = bor_src;
    end

    // A hardware set wins over a software clear in the same cycle.
    // Writing a one only stores it; it never starts a reset.
    always_ff @(posedge clk_in or posedge rst_in)
    begin
        if (rst_in)
            cause_q <= `CAUSE_POR_VAL;
        else if (wr && paddr_in == `OFS_CAUSE)
            cause_q <= (pwdata_in[15:0] & `CAUSE_MASK) | cause_set;
        else
            cause_q <= cause_q | cause_set;
    end

    // ------------------------------------------------------------------
    // Power-on only registers
    // ------------------------------------------------------------------
    // Configuration words are reloaded only at power-on, like the
    // calibration and flash control registers.
    always_ff @(posedge clk_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            rtc_q <= `RTC_RST_VAL;
            flash_q <= `FLASH_RST_VAL;
            cfg2_q <= `CFG2_RST_VAL;
            cfg3_q <= `CFG3_RST_VAL;
        end
        else if (wr)
        begin
            case (paddr_in)
                `OFS_RTC: rtc_q <= pwdata_in[15:0];
                `OFS_FLASH: flash_q <= pwdata_in[15:0];
                `OFS_CFG2: cfg2_q <= pwdata_in[15:0];
                `OFS_CFG3: cfg3_q <= pwdata_in[15:0];
                default: rtc_q <= rtc_q;
            endcase
        end
    end

    // ------------------------------------------------------------------
    // APB slave
    // ------------------------------------------------------------------
    assign acc = psel_in && penable_in;
    assign wr = acc && pwrite_in && decode_hit(paddr_in);
    assign pready_out = 1'b1;
    assign pslverr_out = acc && !decode_hit(paddr_in);

    always_comb
    begin
        case (paddr_in)
            `OFS_CAUSE: rd_mux = cause_q;
            `OFS_OSC: rd_mux = osc_q;
            `OFS_RTC: rd_mux = rtc_q;
            `OFS_FLASH: rd_mux = flash_q;
            `OFS_CFG2: rd_mux = cfg2_q;
            `OFS_CFG3: rd_mux = cfg3_q;
            `OFS_STATUS: rd_mux = {2'h0, clk_rel, mon_q, ck_q, 3'h0, state_q};
            default: rd_mux = 16'h0000;
        endcase
    end

    // Read data is captured in the setup cycle so it leaves a flop.
    always_ff @(posedge clk_in or posedge rst_in)
    begin
        if (rst_in)
            prdata_out <= 32'h0000_0000;
        else if (psel_in && !penable_in)
            prdata_out <= {16'h0000, rd_mux};
    end

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    default clocking @(posedge clk_in); endclocking
    default disable iff (rst_in);

    sequence por_to_vreg_s;
        state_q == reset_seq_pkg::ST_POR && cnt_q == '0 && !any_src;
    endsequence

    sequence vreg_start_s;
        state_q == reset_seq_pkg::ST_VREG && cnt_q == 12'(`VREG_CYC - 1);
    endsequence

    por_stage_order_a: assert property (
        por_to_vreg_s |=> vreg_start_s)
        else $error("regulator delay did not follow power-on delay");
    source_holds_reset_a: assert property (
        any_src |=> system_reset_out [*2])
        else $error("reset released while a source was active");
    short_reset_a: assert property (
        state_q == reset_seq_pkg::ST_HOLD && !any_src &&
        kind_q == reset_seq_pkg::KIND_OTHER |=>
        state_q == reset_seq_pkg::ST_RST && cnt_q == 12'(`RST_CYC - 1))
        else $error("internal reset time wrong");
    cpu_gate_a: assert property (
        system_reset_out || (!two_q && ck_q != reset_seq_pkg::CK_DONE) |->
        !cpu_run_out)
        else $error("code ran without clock or in reset");
    bor_reset_a: assert property (
        brown_out_in && cfg3_q[`CFG3_BO_EN] |=>
        system_reset_out && kind_q != reset_seq_pkg::KIND_OTHER)
        else $error("brown-out did not reset the device");
    wdt_flag_a: assert property (
        watchdog_timeout_reset_in |=> cause_q[`CAUSE_WDT])
        else $error("watchdog flag not set");
    bor_osc_sel_a: assert property (
        reselect && bor_src && !cfg3_q[`CFG3_TWOSPD] |=>
        active_osc_out == $past(cfg2_q[`CFG2_INIT_HI:`CFG2_INIT_LO]))
        else $error("brown-out did not take configured source");
    fail_switch_a: assert property (
        mon_q && !clk_present_in && !system_reset_out && !any_src |=>
        ##[0:1] active_osc_out == reset_seq_pkg::SRC_FAST_RC)
        else $error("fail monitor did not fall back to the fast RC");
    rtc_keep_a: assert property (
        any_src && !wr |=> $stable(rtc_q) && $stable(flash_q))
        else $error("calibration changed by non power-on reset");

endmodule

// ===== reset_release_sequencer_tb.sv
`timescale 1ns/1ps
module reset_release_sequencer_tb;
logic clk_in, rst_in, psel_in, penable_in, pwrite_in, slv_q;
logic [7:0] paddr_in;
logic [31:0] pwdata_in, prdata_out, rd_q;
logic pready_out, pslverr_out, brown_out_in, osc_tick_in, pll_lock_in;
logic clk_present_in, system_reset_out, cpu_run_out, clock_fail_out;
logic [2:0] active_osc_out;
logic [5:0] src_q;
int error_cnt, num_checks, n, k, rtc_m;
int bits[6] = '{7, 4, 6, 14, 14, 15};

reset_release_sequencer reset_release_sequencer_i (
    .clk_in, .rst_in, .psel_in, .penable_in, .pwrite_in, .paddr_in,
    .pwdata_in, .prdata_out, .pready_out, .pslverr_out, .brown_out_in,
    .external_reset_pin_in(src_q[0]), .watchdog_timeout_reset_in(src_q[1]),
    .software_reset_instr_in(src_q[2]), .illegal_opcode_in(src_q[3]),
    .uninit_wreg_in(src_q[4]), .trap_conflict_in(src_q[5]), .osc_tick_in,
    .pll_lock_in, .clk_present_in, .system_reset_out, .cpu_run_out,
    .clock_fail_out, .active_osc_out
);

initial
begin
    clk_in = 1'b0;
    forever #2.5 clk_in = ~clk_in;
end

// ----------------------------------------------------------------------
// Shared tasks
// ----------------------------------------------------------------------
task chk(input string s, input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
        error_cnt++;
        $display("unexpected %s: expected %h seen %h", s, exp, seen);
    end
endtask

task results;
    $display("checks %0d mismatches %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0)
        $display("ALL TESTS PASSED");
    else
        $display("TESTS FAILED");
    $finish;
endtask

// Starts one edge on so that no signal is assigned twice in a time step.
task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int t;
    @(posedge clk_in);
    psel_in <= 1'b1;
    penable_in <= 1'b0;
    pwrite_in <= w;
    paddr_in <= a;
    pwdata_in <= d;
    @(posedge clk_in);
    penable_in <= 1'b1;
    t = 0;
    do
    begin
        @(posedge clk_in);
        t++;
    end
    while (pready_out !== 1'b1 && t < 50);
    if (t >= 50)
    begin
        error_cnt++;
        results();
    end
    rd_q = prdata_out;
    slv_q = pslverr_out;
    psel_in <= 1'b0;
    penable_in <= 1'b0;
endtask

task rdchk(input logic [7:0] a, input logic [31:0] e, input string s);
    apb(1'b0, a, 32'h0);
    chk(s, rd_q, e);
endtask

task wait_rst(input logic lvl, input int max);
    n = 0;
    while (system_reset_out !== lvl && n < max)
    begin
        @(posedge clk_in);
        n++;
    end
    if (n >= max)
    begin
        error_cnt++;
        results();
    end
endtask

// Two-cycle brown-out, then wait for the release.
task bor_rst;
    @(posedge clk_in);
    brown_out_in <= 1'b1;
    repeat (2) @(posedge clk_in);
    brown_out_in <= 1'b0;
    @(posedge clk_in);
    wait_rst(1'b0, 3000);
endtask

task ticks;
    repeat (1024)
    begin
        @(posedge clk_in);
        osc_tick_in <= 1'b1;
        @(posedge clk_in);
        osc_tick_in <= 1'b0;
    end
endtask

// ----------------------------------------------------------------------
// Main sequence
// ----------------------------------------------------------------------
initial
begin
    rst_in = 1'b1; psel_in = 1'b0; penable_in = 1'b0; pwrite_in = 1'b0;
    paddr_in = 8'h00; pwdata_in = 32'h0; src_q = 6'h0; brown_out_in = 1'b0;
    osc_tick_in = 1'b0; pll_lock_in = 1'b1; clk_present_in = 1'b1;
    void'($urandom(65014));
    repeat (5) @(posedge clk_in);
    rst_in <= 1'b0;
    wait_rst(1'b0, 6000);
    chk("por delay", 32'(n >= 4395 && n <= 4405), 32'h1);
    chk("run after por", 32'(cpu_run_out), 32'h1);
    rdchk(8'h00, 32'h0003, "cause");
    rdchk(8'h04, 32'h0000, "osc");
    rdchk(8'h10, 32'h0080, "cfg2");
    rdchk(8'h14, 32'h1000, "cfg3");
    rdchk(8'h0c, 32'h0000, "flash");
    rdchk(8'h1c, 32'h0000, "unmapped");
    chk("slverr", 32'(slv_q), 32'h1);
    $display("test power-on done");
    for (int i = 0; i < 6; i++)
    begin
        rtc_m = $urandom & 32'hffff;
        apb(1'b1, 8'h08, rtc_m);
        apb(1'b1, 8'h00, 32'h0);
        @(posedge clk_in);
        src_q <= 6'h1 << i;
        repeat ($urandom_range(3, 0)) @(posedge clk_in);
        @(posedge clk_in);
        src_q <= 6'h0;
        @(posedge clk_in);
        chk("held", 32'(system_reset_out), 32'h1);
        wait_rst(1'b0, 1000);
        chk("short delay", 32'(n >= 395 && n <= 405), 32'h1);
        rdchk(8'h00, 32'h1 << bits[i], "flag");
        rdchk(8'h08, rtc_m, "rtc kept");
    end
    $display("test short resets done");
    apb(1'b1, 8'h00, 32'h0080);
    repeat (3) @(posedge clk_in);
    chk("soft flag", 32'(system_reset_out), 32'h0);
    apb(1'b1, 8'h10, 32'h0480);
    apb(1'b1, 8'h14, 32'h1400);
    apb(1'b1, 8'h00, 32'h0);
    bor_rst();
    chk("bor delay", 32'(n >= 2395 && n <= 2405), 32'h1);
    chk("no clock", 32'(cpu_run_out), 32'h0);
    ticks();
    for (k = 0; k < 20 && cpu_run_out !== 1'b1; k++) @(posedge clk_in);
    chk("crystal run", 32'(cpu_run_out), 32'h1);
    chk("crystal osc", 32'(active_osc_out), 32'h4);
    rdchk(8'h00, 32'h0002, "bor flag");
    @(posedge clk_in);
    clk_present_in <= 1'b0;
    for (k = 0; k < 5 && clock_fail_out !== 1'b1; k++) @(posedge clk_in);
    chk("fail pulse", 32'(clock_fail_out), 32'h1);
    @(posedge clk_in);
    chk("fallback", 32'(active_osc_out), 32'h0);
    clk_present_in <= 1'b1;
    apb(1'b1, 8'h14, 32'h1c00);
    apb(1'b1, 8'h00, 32'h0);
    bor_rst();
    chk("two-speed run", 32'(cpu_run_out), 32'h1);
    chk("two-speed rc", 32'(active_osc_out), 32'h0);
    ticks();
    repeat (4) @(posedge clk_in);
    chk("two-speed switch", 32'(active_osc_out), 32'h4);
    apb(1'b1, 8'h14, 32'h0);
    @(posedge clk_in);
    brown_out_in <= 1'b1;
    repeat (5) @(posedge clk_in);
    chk("bor off", 32'(system_reset_out), 32'h0);
    brown_out_in <= 1'b0;
    $display("test brown-out and clock done");
    rst_in <= 1'b1;
    repeat (2) @(posedge clk_in);
    rst_in <= 1'b0;
    rdchk(8'h08, 32'h0000, "rtc por");
    rdchk(8'h00, 32'h0003, "cause por");
    rdchk(8'h10, 32'h0080, "cfg2 por");
    chk("osc por", 32'(active_osc_out), 32'h0);
    $display("test second power-on done");
    results();
end

initial
begin
    #500000;
    error_cnt++;
    results();
end
endmodule
